// ==== rtl/ddrc_cmd_if.sv ====
// Device-side command, clock-enable and data interface of a four-bank DDR memory
`timescale 1ns/100ps
`include "ddrc_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// R1: Sample command inputs on link clock rise
// R2: Drive read data on both link edges
// R3: CKE low freezes outputs and burst state; here write beats still advance on strobe edges
// R4: CKE low with banks idle enters low power
// R5: Bank select picks target of each command
// R6: Capture 13-bit row, 10-bit column address
// R7: Address bit ten requests auto precharge
// R8: Chip select high masks every command
// R9: CS RAS low, CAS WE high opens row
// R10: CS RAS WE low, CAS high closes row
// R11: CAS low starts read or write by WE
// R12: Row must be open before column access
// R13: Burst length two, four or eight
// R14: Sequential or interleaved burst order
// R15: Read latency two, two-half or three
// R16: Auto precharge closes row after burst
// R17: Controller refreshes 8192 rows per 64 ms
// R18: Byte mask sampled with its data word
// R19: DLL enabled or disabled by extended mode
// R20: Four banks of 8M sixteen-bit words
// R21: Each data strobe times its own byte; here any strobe edge takes the whole word
// R22: Mask high blocks that byte from storage
// R23: CKE high again resumes from frozen state
module ddrc_cmd_if (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link pins
   input wire logic link_ck,
   input wire ddrc_pkg::ddrc_cmd_pins_type pins,
   input wire logic [`DDRC_DQ_W-1:0] dq_in,
   output logic [`DDRC_DQ_W-1:0] dq_out,
   output logic dq_oe_n,
   input wire logic [`DDRC_LANES-1:0] dqs_in,
   output logic [`DDRC_LANES-1:0] dqs_out,
   output logic [`DDRC_LANES-1:0] dqs_oe_n,
   input wire logic [`DDRC_LANES-1:0] dm_in,
   // Mode settings
   input wire ddrc_pkg::ddrc_burst_len_type cfg_burst_len,
   input wire logic cfg_interleave,
   input wire ddrc_pkg::ddrc_cas_lat_type cfg_cas_lat,
   // Write word stream to storage
   output logic wr_valid,
   input wire logic wr_ready,
   output ddrc_pkg::ddrc_wr_beat_type wr_beat,
   output logic wr_space,
   // Read word requests and returned data
   output logic rd_req_valid,
   output ddrc_pkg::ddrc_loc_type rd_req_loc,
   input wire logic [`DDRC_DQ_W-1:0] rd_word,
   // Status
   output ddrc_pkg::ddrc_pwr_type pwr_state,
   output logic dll_enable,
   output logic [`DDRC_BANKS-1:0] bank_open,
   output logic access_error,
   output logic refresh_pulse
);
   import ddrc_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // Signals

   logic ck_s1, ck_s2, ck_s3;
   ddrc_cmd_pins_type pins_s1, pins_s2;
   logic [`DDRC_DQ_W-1:0] dq_s1, dq_s2;
   logic [`DDRC_LANES-1:0] dm_s1, dm_s2;
   logic [`DDRC_LANES-1:0] dqs_s1, dqs_s2, dqs_s3;
   logic rise, fall, tick, cke_q, cmd_take;
   ddrc_cmd_type cmd;
   logic [`DDRC_ROW_W-1:0] bank_row [`DDRC_BANKS]; // R20
   logic all_idle, col_ok;
   ddrc_burst_type burst_kind;
   ddrc_loc_type burst_loc;
   logic [2:0] burst_mask, burst_wait, burst_beat;
   logic burst_ap, burst_il, rd_drive, beat_tick, burst_last, burst_end;
   logic dqs_edge, wr_push;
   ddrc_wr_beat_type next_wr_beat;
   logic [2:0] next_rd_idx;

   // Command decode from the strobe pins
   function automatic ddrc_cmd_type ddrc_decode(input ddrc_cmd_pins_type p);
      ddrc_cmd_type c;
      c = DDRC_NOP;
      if (!p.cs_n) begin // R8
         unique case ({p.ras_n, p.cas_n, p.we_n})
            3'b011: c = DDRC_ROW_OPEN; // R9
            3'b010: c = DDRC_ROW_CLOSE; // R10
            3'b101: c = DDRC_READ; // R11
            3'b100: c = DDRC_WRITE; // R11
            3'b000: c = DDRC_MODE_SET;
            3'b001: c = DDRC_REFRESH;
            default: c = DDRC_NOP;
         endcase
      end
      return c;
   endfunction : ddrc_decode

   // Column of one beat inside the burst window
   function automatic logic [`DDRC_COL_W-1:0] ddrc_burst_col(
      input logic [`DDRC_COL_W-1:0] base,
      input logic [2:0] idx,
      input logic [2:0] mask,
      input logic il
   );
      logic [2:0] low;
      low = il ? (base[2:0] ^ idx) : 3'(base[2:0] + idx); // R14
      return {base[`DDRC_COL_W-1:3], (base[2:0] & ~mask) | (low & mask)};
   endfunction : ddrc_burst_col

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Two flip-flops on every link input, a third on link clock and strobes for edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
         pins_s1 <= '0;
         pins_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
         dm_s1 <= '0;
         dm_s2 <= '0;
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_s3 <= '0;
      end else begin
         ck_s1 <= link_ck;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
         pins_s1 <= pins;
         pins_s2 <= pins_s1;
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         dm_s1 <= dm_in;
         dm_s2 <= dm_s1;
         dqs_s1 <= dqs_in;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
      end
   end

   // Link clock edges; the rise is the true/complement crossing
   assign rise = ck_s2 && !ck_s3; // R1
   assign fall = !ck_s2 && ck_s3;
   // Internal phase advances only while the clock is enabled
   assign tick = (rise || fall) && cke_q; // R3
   assign cmd = ddrc_decode(pins_s2);
   assign cmd_take = rise && cke_q && pins_s2.cke; // R1
   assign all_idle = (bank_open == '0);
   assign col_ok = bank_open[pins_s2.ba]; // R12

   //////////////////////////////////////////////////////////////////////////
   // Clock enable and power state

   // Clock enable as seen at the last rise
   always_ff @(posedge clk) begin
      if (srst) begin
         cke_q <= 1'b1;
      end else if (rise) begin
         cke_q <= pins_s2.cke; // R3
      end
   end

   // Suspension, power-down and self-refresh entry and exit
   always_ff @(posedge clk) begin
      if (srst) begin
         pwr_state <= DDRC_PWR_RUN;
      end else if (rise) begin
         if (pins_s2.cke) begin
            pwr_state <= DDRC_PWR_RUN; // R23
         end else if (cke_q && all_idle && cmd == DDRC_REFRESH) begin
            pwr_state <= DDRC_PWR_SELF_REFRESH; // R4
         end else if (cke_q) begin
            pwr_state <= all_idle ? DDRC_PWR_DOWN : DDRC_PWR_SUSPEND; // R4
         end
      end
   end

   // Auto refresh pulse
   always_ff @(posedge clk) begin
      if (srst) begin
         refresh_pulse <= 1'b0;
      end else begin
         refresh_pulse <= cmd_take && cmd == DDRC_REFRESH;
      end
   end

   // Extended mode set steers the DLL enable
   always_ff @(posedge clk) begin
      if (srst) begin
         dll_enable <= `DDRC_DLL_RESET;
      end else if (cmd_take && cmd == DDRC_MODE_SET && pins_s2.ba == `DDRC_EXT_MODE_BANK) begin
         dll_enable <= !pins_s2.addr[`DDRC_DLL_DIS_BIT]; // R19
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Bank state

   // Open rows per bank; four banks, each addressed by bank select
   always_ff @(posedge clk) begin
      if (srst) begin
         bank_open <= '0;
         for (int i = 0; i < `DDRC_BANKS; i++) begin
            bank_row[i] <= '0;
         end
      end else begin
         if (burst_end && burst_ap) begin
            bank_open[burst_loc.bank] <= 1'b0; // R16
         end
         if (cmd_take && cmd == DDRC_ROW_OPEN) begin
            bank_open[pins_s2.ba] <= 1'b1; // R9
            bank_row[pins_s2.ba] <= pins_s2.addr; // R6
         end else if (cmd_take && cmd == DDRC_ROW_CLOSE) begin
            bank_open[pins_s2.ba] <= 1'b0; // R10
         end
      end
   end

   // Column access to a closed bank is ignored and flagged
   always_ff @(posedge clk) begin
      if (srst) begin
         access_error <= 1'b0;
      end else begin
         access_error <= cmd_take && (cmd == DDRC_READ || cmd == DDRC_WRITE) && !col_ok; // R12
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Burst engine

   assign beat_tick = tick && burst_kind == DDRC_BURST_READ && burst_wait == 3'h1;
   assign burst_last = (burst_beat == burst_mask);
   assign dqs_edge = (dqs_s2 != dqs_s3);
   assign wr_push = dqs_edge && burst_kind == DDRC_BURST_WRITE;
   assign burst_end = (beat_tick || wr_push) && burst_last;

   // Column command loads the burst; read beats advance on link phases, write beats on strobe edges
   always_ff @(posedge clk) begin
      if (srst) begin
         burst_kind <= DDRC_BURST_IDLE;
         burst_loc <= '0;
         burst_mask <= '0;
         burst_wait <= '0;
         burst_beat <= '0;
         burst_ap <= 1'b0;
         burst_il <= 1'b0;
      end else if (cmd_take && (cmd == DDRC_READ || cmd == DDRC_WRITE) && col_ok) begin
         burst_kind <= (cmd == DDRC_READ) ? DDRC_BURST_READ : DDRC_BURST_WRITE; // R11
         burst_loc.bank <= pins_s2.ba; // R5
         burst_loc.row <= bank_row[pins_s2.ba];
         burst_loc.col <= pins_s2.addr[`DDRC_COL_W-1:0]; // R6
         burst_ap <= pins_s2.addr[`DDRC_AP_BIT]; // R7
         burst_il <= cfg_interleave; // R14
         burst_beat <= '0;
         unique case (cfg_burst_len) // R13
            DDRC_BL2: burst_mask <= `DDRC_BL2_MASK;
            DDRC_BL4: burst_mask <= `DDRC_BL4_MASK;
            DDRC_BL8: burst_mask <= `DDRC_BL8_MASK;
            default: burst_mask <= `DDRC_BL2_MASK;
         endcase
         unique case (cfg_cas_lat) // R15
            DDRC_CL2: burst_wait <= `DDRC_CL2_PHASES;
            DDRC_CL25: burst_wait <= `DDRC_CL25_PHASES;
            DDRC_CL3: burst_wait <= `DDRC_CL3_PHASES;
            default: burst_wait <= `DDRC_CL2_PHASES;
         endcase
      end else if (burst_end) begin
         burst_kind <= DDRC_BURST_IDLE; // R16
      end else if (beat_tick || wr_push) begin
         burst_beat <= burst_beat + 3'h1;
      end else if (tick && burst_kind == DDRC_BURST_READ && burst_wait > 3'h1) begin
         burst_wait <= burst_wait - 3'h1; // R3
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read path

   // Word for the next beat is asked for one link phase ahead
   assign next_rd_idx = (burst_wait == 3'h2) ? 3'h0 : 3'(burst_beat + 3'h1);
   // Read word requests
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_req_valid <= 1'b0;
         rd_req_loc <= '0;
      end else begin
         rd_req_valid <= 1'b0;
         if (tick && burst_kind == DDRC_BURST_READ
             && (burst_wait == 3'h2 || (burst_wait == 3'h1 && !burst_last))) begin
            rd_req_valid <= 1'b1;
            rd_req_loc.bank <= burst_loc.bank;
            rd_req_loc.row <= burst_loc.row;
            rd_req_loc.col <= ddrc_burst_col(burst_loc.col, next_rd_idx, burst_mask, burst_il);
         end
      end
   end

   // Data and strobes leave on every link phase of the burst
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_drive <= 1'b0;
         dq_out <= '0;
         dqs_out <= '0;
      end else if (tick) begin // R3
         if (burst_kind == DDRC_BURST_READ && burst_wait == 3'h2) begin
            rd_drive <= 1'b1;
            dqs_out <= '0;
         end else if (beat_tick) begin
            dq_out <= rd_word; // R2
            dqs_out <= {`DDRC_LANES{!burst_beat[0]}}; // R21
         end else begin
            rd_drive <= 1'b0;
            dqs_out <= '0;
         end
      end
   end

   // Pins driven only inside the read window, enable active low
   assign dq_oe_n = !rd_drive;
   assign dqs_oe_n = {`DDRC_LANES{!rd_drive}};

   //////////////////////////////////////////////////////////////////////////
   // Write path

   // Each strobe edge takes one word together with its masks
   always_comb begin
      next_wr_beat.loc.bank = burst_loc.bank;
      next_wr_beat.loc.row = burst_loc.row;
      next_wr_beat.loc.col = ddrc_burst_col(burst_loc.col, burst_beat, burst_mask, burst_il);
      next_wr_beat.data = dq_s2; // R21
      next_wr_beat.mask = dm_s2; // R18 R22
   end

   // Written words queue toward storage
   ddrc_fifo #(
      .WIDTH($bits(ddrc_wr_beat_type)),
      .DEPTH(`DDRC_FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(wr_push),
      .in_ready(wr_space),
      .in_data(next_wr_beat),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_beat)
   );
endmodule : ddrc_cmd_if

// ==== rtl/ddrc_fifo.sv ====
// Small FIFO with a registered output word
`timescale 1ns/100ps
module ddrc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   logic [AW:0] count;
   logic load;
   logic push;

   // Fill level and handshakes
   assign count = wp - rp;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign load = (count != '0) && (!out_valid || out_ready);

   // Storage writes
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (srst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (load) begin
            rp <= rp + 1'b1;
         end
      end
   end

   // Output register
   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (load) begin
         out_valid <= 1'b1;
         out_data <= mem[rp[AW-1:0]];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : ddrc_fifo

// ==== rtl/ddrc_map.svh ====
// Constants of the DDR command interface: widths, bit positions, reset values, counts
`ifndef DDRC_MAP_SVH
`define DDRC_MAP_SVH

`define DDRC_ROW_W 13
`define DDRC_COL_W 10
`define DDRC_BANK_W 2
`define DDRC_BANKS 4
`define DDRC_DQ_W 16
`define DDRC_LANES 2
`define DDRC_AP_BIT 10
`define DDRC_EXT_MODE_BANK 2'h1
`define DDRC_DLL_DIS_BIT 0
`define DDRC_DLL_RESET 1'h1
`define DDRC_FIFO_DEPTH 8
`define DDRC_CL2_PHASES 3'h4
`define DDRC_CL25_PHASES 3'h5
`define DDRC_CL3_PHASES 3'h6
`define DDRC_BL2_MASK 3'h1
`define DDRC_BL4_MASK 3'h3
`define DDRC_BL8_MASK 3'h7

`endif

// ==== rtl/ddrc_pkg.sv ====
// Types shared by the DDR command interface and its test side
package ddrc_pkg;
   `include "ddrc_map.svh"

   // Decoded command codes
   typedef enum logic [2:0] {
      DDRC_NOP = 3'b000,
      DDRC_ROW_OPEN = 3'b001,
      DDRC_ROW_CLOSE = 3'b010,
      DDRC_READ = 3'b011,
      DDRC_WRITE = 3'b100,
      DDRC_MODE_SET = 3'b101,
      DDRC_REFRESH = 3'b110
   } ddrc_cmd_type;

   // Programmed burst length
   typedef enum logic [1:0] {
      DDRC_BL2 = 2'b01,
      DDRC_BL4 = 2'b10,
      DDRC_BL8 = 2'b11
   } ddrc_burst_len_type;

   // Programmed read latency
   typedef enum logic [1:0] {
      DDRC_CL2 = 2'b00,
      DDRC_CL25 = 2'b01,
      DDRC_CL3 = 2'b10
   } ddrc_cas_lat_type;

   // Clock and power state
   typedef enum logic [1:0] {
      DDRC_PWR_RUN = 2'b00,
      DDRC_PWR_SUSPEND = 2'b01,
      DDRC_PWR_DOWN = 2'b10,
      DDRC_PWR_SELF_REFRESH = 2'b11
   } ddrc_pwr_type;

   // Burst engine state
   typedef enum logic [1:0] {
      DDRC_BURST_IDLE = 2'b00,
      DDRC_BURST_READ = 2'b01,
      DDRC_BURST_WRITE = 2'b10
   } ddrc_burst_type;

   // Command pins as seen at the package
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [`DDRC_BANK_W-1:0] ba;
      logic [`DDRC_ROW_W-1:0] addr;
   } ddrc_cmd_pins_type;

   // Location of one data word
   typedef struct packed {
      logic [`DDRC_BANK_W-1:0] bank;
      logic [`DDRC_ROW_W-1:0] row;
      logic [`DDRC_COL_W-1:0] col;
   } ddrc_loc_type;

   // One written word with its byte masks
   typedef struct packed {
      ddrc_loc_type loc;
      logic [`DDRC_DQ_W-1:0] data;
      logic [`DDRC_LANES-1:0] mask;
   } ddrc_wr_beat_type;
endpackage : ddrc_pkg

// ==== verif/ddrc_cmd_if_bench.sv ====
// Self-checking bench of the DDR command interface
`timescale 1ns/100ps
module ddrc_cmd_if_bench;
   import ddrc_pkg::*;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic link_ck, dq_oe_n, cfg_interleave, wr_valid, wr_space, rd_req_valid;
   logic wr_ready = 1'h0;
   logic dll_enable, access_error, refresh_pulse;
   ddrc_cmd_pins_type pins;
   logic [15:0] dq_in, dq_out;
   logic [15:0] rd_word = 16'h0;
   logic [1:0] dqs_in, dqs_out, dqs_oe_n, dm_in;
   logic [1:0] last_dqs = 2'h0;
   ddrc_burst_len_type cfg_burst_len;
   ddrc_cas_lat_type cfg_cas_lat;
   ddrc_wr_beat_type wr_beat;
   ddrc_loc_type rd_req_loc;
   ddrc_pwr_type pwr_state;
   logic [3:0] bank_open;
   logic [12:0] rows [4];
   ddrc_loc_type exp_loc [$];
   logic [15:0] exp_rd [$];
   ddrc_wr_beat_type exp_wr [$];
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int errs = 0;
   int refs = 0;
   // System clock of 10 ns
   always #5 clk = ~clk;
   ddrc_cmd_if DUT (
      .clk(clk), .srst(srst), .link_ck(link_ck), .pins(pins), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
      .dm_in(dm_in), .cfg_burst_len(cfg_burst_len), .cfg_interleave(cfg_interleave),
      .cfg_cas_lat(cfg_cas_lat), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat),
      .wr_space(wr_space), .rd_req_valid(rd_req_valid), .rd_req_loc(rd_req_loc),
      .rd_word(rd_word), .pwr_state(pwr_state), .dll_enable(dll_enable),
      .bank_open(bank_open), .access_error(access_error), .refresh_pulse(refresh_pulse)
   );
   ddrc_ctrl_model ctl (
      .link_ck(link_ck), .pins(pins), .dq_in(dq_in), .dqs_in(dqs_in), .dm_in(dm_in)
   );
   ////////////////
   function automatic logic [15:0] word_of(input ddrc_loc_type l);
      return {l.bank, l.col, l.row[3:0]};
   endfunction : word_of
   // Burst column order: wrap inside the burst, or exclusive-or of the index
   function automatic logic [9:0] col_at(input logic [9:0] b, input int i, input int bl,
         input logic il);
      logic [9:0] m;
      m = 10'(bl - 1);
      return il ? (b ^ 10'(i)) : ((b & ~m) | ((b + 10'(i)) & m));
   endfunction : col_at
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (exp !== got) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic complete_run(input logic hung);
      if (hung) num_errors++;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   // Storage side: answers requests, stalls writes, compares results with oldest notes
   always @(negedge clk) begin
      logic rdy;
      rdy = $urandom_range(1, 0);
      cycles++;
      if (access_error) errs++;
      if (refresh_pulse) refs++;
      if (rd_req_valid) rd_word <= word_of(rd_req_loc);
      if (rd_req_valid) check("read location", exp_loc.pop_front(), rd_req_loc);
      if (wr_valid && rdy) check("write word", exp_wr.pop_front(), wr_beat);
      if (!dqs_oe_n[0] && dqs_out != last_dqs) check("read beat", exp_rd.pop_front(), dq_out);
      last_dqs <= dqs_out;
      wr_ready <= rdy;
      if (cycles == 20000) complete_run(1'h1);
   end
   // Bounded wait until every noted result has been seen
   task automatic drain();
      for (int k = 0; k < 400 && exp_wr.size() + exp_rd.size() + exp_loc.size() > 0; k++)
         @(negedge clk);
      repeat (3) @(negedge clk);
      check("results left", 0, exp_wr.size() + exp_rd.size() + exp_loc.size());
      check("write space", 1, wr_space);
   endtask : drain
   // One column access with its expected words noted beforehand
   task automatic access(input logic wr, input logic [1:0] ba, input int bl, input logic il,
         input logic ap);
      logic [15:0] d [8];
      logic [1:0] m [8];
      logic [9:0] col;
      ddrc_loc_type l;
      col = $urandom;
      cfg_burst_len = ddrc_burst_len_type'(2'(bl / 3 + 1));
      cfg_interleave = il;
      cfg_cas_lat = ddrc_cas_lat_type'(2'($urandom_range(2, 0)));
      for (int i = 0; i < bl; i++) begin
         l = '{ba, rows[ba], col_at(col, i, bl, il)};
         d[i] = $urandom;
         m[i] = $urandom;
         if (wr) exp_wr.push_back('{l, d[i], m[i]});
         if (!wr) exp_loc.push_back(l);
         if (!wr) exp_rd.push_back(word_of(l));
      end
      ctl.issue({4'hA, !wr}, ba, {2'h0, ap, col});
      if (wr) ctl.burst(bl, d, m);
      drain();
   endtask : access
   // Main sequence
   initial begin
      void'($urandom(92));
      cfg_burst_len = DDRC_BL2;
      cfg_interleave = 1'h0;
      cfg_cas_lat = DDRC_CL2;
      repeat (10) @(negedge clk);
      srst = 1'h0;
      check("dll reset value", 1, dll_enable);
      ctl.issue(5'h1B, 2'h0, 13'h0);
      ctl.issue(5'h15, 2'h1, 13'h0);
      repeat (5) @(negedge clk);
      check("masked open", 0, bank_open);
      check("closed bank read", 1, errs);
      for (int b = 0; b < 4; b++) begin
         rows[b] = $urandom;
         ctl.issue(5'h13, 2'(b), rows[b]);
      end
      repeat (5) @(negedge clk);
      check("rows open", 4'hF, bank_open);
      for (int k = 0; k < 12; k++) access(k[0], 2'($urandom), 2 << (k / 4), k[1], 1'h0);
      access(1'h0, 2'h3, 2, 1'h1, 1'h1);
      check("auto precharge", 4'h7, bank_open);
      ctl.issue(5'h12, 2'h2, 13'h0);
      repeat (5) @(negedge clk);
      check("precharge", 4'h3, bank_open);
      // Clock enable drops in the middle of a read burst, which resumes afterwards
      fork
         access(1'h0, 2'h0, 8, 1'h0, 1'h0);
         begin
            repeat (3) @(negedge link_ck);
            ctl.issue(5'h0F, 2'h0, 13'h0);
            repeat (30) @(negedge clk);
            check("suspend", DDRC_PWR_SUSPEND, pwr_state);
            ctl.issue(5'h1F, 2'h0, 13'h0);
         end
      join
      check("resume", DDRC_PWR_RUN, pwr_state);
      ctl.issue(5'h12, 2'h0, 13'h0);
      ctl.issue(5'h12, 2'h1, 13'h0);
      ctl.issue(5'h0F, 2'h0, 13'h0);
      repeat (5) @(negedge clk);
      check("power down", DDRC_PWR_DOWN, pwr_state);
      ctl.issue(5'h1F, 2'h0, 13'h0);
      ctl.issue(5'h01, 2'h0, 13'h0);
      repeat (5) @(negedge clk);
      check("self refresh", DDRC_PWR_SELF_REFRESH, pwr_state);
      ctl.issue(5'h1F, 2'h0, 13'h0);
      ctl.issue(5'h11, 2'h0, 13'h0);
      ctl.issue(5'h10, 2'h1, 13'h1);
      repeat (5) @(negedge clk);
      check("auto refresh", 1, refs);
      check("dll off", 0, dll_enable);
      ctl.issue(5'h10, 2'h1, 13'h0);
      repeat (5) @(negedge clk);
      check("dll on", 1, dll_enable);
      complete_run(1'h0);
   end
endmodule : ddrc_cmd_if_bench

// ==== verif/ddrc_cmd_if_properties.sv ====
// Port checker of the DDR command interface, bound to its top module
`timescale 1ns/100ps
`include "ddrc_map.svh"
module ddrc_cmd_if_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Read side
   input wire logic [`DDRC_DQ_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic [`DDRC_LANES-1:0] dqs_out,
   input wire logic [`DDRC_LANES-1:0] dqs_oe_n,
   input wire logic rd_req_valid,
   input wire ddrc_pkg::ddrc_loc_type rd_req_loc,
   // Write side and status
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire ddrc_pkg::ddrc_wr_beat_type wr_beat,
   input wire ddrc_pkg::ddrc_pwr_type pwr_state,
   input wire logic [`DDRC_BANKS-1:0] bank_open,
   input wire logic access_error
);
   import ddrc_pkg::*;
   // Every check runs on the system clock and rests during reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   ////////////////
   property p_oe_pair;
      dq_oe_n ? (dqs_oe_n == 2'h3) : (dqs_oe_n == 2'h0);
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("data and strobe enables differ");
   property p_dqs_pair;
      !dqs_oe_n[0] |-> dqs_out[0] == dqs_out[1];
   endproperty
   a_dqs_pair: assert property (p_dqs_pair) else $error("byte strobes differ");
   property p_dqs_phase;
      !dq_oe_n && $past(dq_oe_n) == 1'h0 && $changed(dqs_out) |=> $stable(dqs_out) [*4];
   endproperty
   a_dqs_phase: assert property (p_dqs_phase) else $error("read beat shorter than a phase");
   property p_err_pulse;
      access_error |=> !access_error;
   endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("access error too long");
   property p_err_banks;
      access_error |-> $stable(bank_open);
   endproperty
   a_err_banks: assert property (p_err_banks) else $error("refused access moved banks");
   property p_lowpwr_idle;
      pwr_state inside {DDRC_PWR_DOWN, DDRC_PWR_SELF_REFRESH} |-> bank_open == 4'h0;
   endproperty
   a_lowpwr_idle: assert property (p_lowpwr_idle) else $error("low power with open bank");
   property p_freeze;
      pwr_state == DDRC_PWR_SUSPEND && $past(pwr_state, 2) == DDRC_PWR_SUSPEND
         |-> $stable(dqs_out) && $stable(dq_out) && !rd_req_valid;
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while suspended");
   property p_rd_open;
      rd_req_valid |-> bank_open[rd_req_loc.bank];
   endproperty
   a_rd_open: assert property (p_rd_open) else $error("read from a closed bank");
   property p_wr_hold;
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_beat);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write word dropped or changed");
   // Main scenarios reached
   c_read: cover property (rd_req_valid);
   c_self: cover property (pwr_state == DDRC_PWR_SELF_REFRESH);
   c_err: cover property (access_error);
   c_susp: cover property (pwr_state == DDRC_PWR_SUSPEND && !dq_oe_n);
endmodule : ddrc_cmd_if_properties

bind ddrc_cmd_if ddrc_cmd_if_properties u_props (
   .clk(clk), .srst(srst), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out),
   .dqs_oe_n(dqs_oe_n), .rd_req_valid(rd_req_valid), .rd_req_loc(rd_req_loc),
   .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat), .pwr_state(pwr_state),
   .bank_open(bank_open), .access_error(access_error)
);

// ==== verif/ddrc_ctrl_model.sv ====
// Memory controller model: free link clock, command pins and write beats
`timescale 1ns/100ps
module ddrc_ctrl_model (
   // Link pins toward the device
   output logic link_ck,
   output ddrc_pkg::ddrc_cmd_pins_type pins,
   output logic [15:0] dq_in,
   output logic [1:0] dqs_in,
   output logic [1:0] dm_in
);
   import ddrc_pkg::*;
   // Pins deselected and idle at start
   initial begin
      link_ck = 1'h0;
      pins = {5'h1F, 15'h0};
      dq_in = 16'h5A5A;
      dqs_in = 2'h0;
      dm_in = 2'h0;
   end
   // Link clock of 125 ns
   always #62.5 link_ck = ~link_ck;
   // One command held round one link rise, then deselect with the bus inverted
   // Pins move a little after the link fall so they never meet a system clock edge
   task automatic issue(input logic [4:0] ctl, input logic [1:0] ba, input logic [12:0] addr);
      @(negedge link_ck);
      #1.5;
      pins = {ctl, ba, addr};
      @(negedge link_ck);
      #1.5;
      pins = {ctl[4], 4'hF, ~ba, ~addr};
   endtask : issue
   // Write beats: word and mask first, then both strobes flip together
   task automatic burst(input int n, input logic [15:0] d [8], input logic [1:0] m [8]);
      for (int i = 0; i < n; i++) begin
         dq_in = d[i];
         dm_in = m[i];
         #30;
         dqs_in = ~dqs_in;
         #32.5;
      end
      dq_in = ~dq_in;
   endtask : burst
endmodule : ddrc_ctrl_model
